// ==== rtl/amc_consts.vh ====
// constants for the asynchronous external memory controller
// assumes inclusion by bare name from rtl/ design files
//
// Summary of operation
// - four banks, each with own timing
// - bank windows 14M and 16M, no remap
// - per bank data width 8, 16, 32
// - drive address for every external access
// - low acknowledge inserts wait states
// - active-low bank select decoded with address
// - selects idle inactive, active for false conditionals
// - read strobe low for each word read
// - write strobe low for each word written
// - reset pin states for address and strobes
// - data pins in memory mode, pulled high
// - selects 2,3 on flag pins, inputs after reset
// - at least six cycles per 32-bit word, one access at a time
// - bank start addresses as decoded below
`ifndef AMC_CONSTS_VH
`define AMC_CONSTS_VH

// ==========================================
// clock
`define CLK_PERIOD_NS 25

// ==========================================
// bank windows (word addresses)
`define BANK0_START 32'h0020_0000
`define BANK0_END 32'h00ff_ffff
`define BANK1_START 32'h0400_0000
`define BANK2_START 32'h0800_0000
`define BANK3_START 32'h0c00_0000
`define BANK_SPAN 32'h00ff_ffff

// ==========================================
// width codes
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2

// ==========================================
// field widths and positions in packed config ports
`define WAIT_BITS 4
`define WIDTH_FIELD 2

// ==========================================
// reset values
`define SEL_IDLE 4'hf
`define ADDR_AFTER_RESET 24'h00_0000

// ==========================================
// unused beat constant; a beat takes at least five cycles
`define BEAT_MIN_CYCLES 3
// strobe cycles before synced ack and data are trusted
`define STROBE_MIN_AGE 2'h2

`endif

// ==== rtl/async_mem_ctrl.v ====
// asynchronous external memory controller: four banks, 8/16/32-bit
// assumes one-cycle request pulses from the core side and async pins
`timescale 1ns/1ps
`include "amc_consts.vh"

module async_mem_ctrl (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // core request
  input wire req,
  input wire req_wr,
  input wire req_cond_true,
  input wire [31:0] req_addr,
  input wire [31:0] req_wdata,
  // core answer
  output reg busy_r,
  output reg done_r,
  output reg addr_err_r,
  output reg [31:0] rdata_r,
  // per bank configuration, bank n in field n
  input wire [4*`WIDTH_FIELD-1:0] cfg_width,
  input wire [4*`WAIT_BITS-1:0] cfg_rd_wait,
  input wire [4*`WAIT_BITS-1:0] cfg_wr_wait,
  // pin multiplexing configuration
  input wire [1:0] cfg_flag_sel_mode,
  input wire cfg_data_alt,
  // address pins
  output reg [23:0] addr_o_r,
  output reg addr_oe_r,
  // data pins
  input wire [31:0] data_i,
  output reg [31:0] data_o_r,
  output reg data_oe_r,
  // control pins
  input wire ack_i,
  output reg [1:0] bank_select_n_r,
  output reg rd_n_r,
  output reg wr_n_r,
  output reg ctl_oe_r,
  // flag pins carrying selects 2 and 3
  output reg [1:0] flag_o_r,
  output reg [1:0] flag_oe_r,
  output reg [1:0] flag_pu_en_r,
  // pin mode status
  output reg ext_memory_pin_mode_r
);

  // ==========================================
  // states
  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_STROBE = 2'h2;
  localparam ST_END = 2'h3;

  reg [1:0] state_r;
  reg [3:0] sel_r;
  reg wr_r;
  reg cond_r;
  reg [1:0] bank_r;
  reg [23:0] offset_r;
  reg [1:0] width_r;
  reg [1:0] beat_r;
  reg [31:0] wdata_r;
  reg [31:0] rbuf_r;
  reg ack_s1_r;
  reg ack_s2_r;
  reg [31:0] data_s1_r;
  reg [31:0] data_s2_r;
  // cycles the strobe has been low in this beat
  reg [1:0] strobe_age_r;

  // ==========================================
  // pin input synchronisers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      data_s1_r <= 32'h0000_0000;
      data_s2_r <= 32'h0000_0000;
    end else begin
      ack_s1_r <= ack_i;
      ack_s2_r <= ack_s1_r;
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end

  // ==========================================
  // decode and per bank selection
  wire dec_hit;
  wire [1:0] dec_bank;
  wire [23:0] dec_offset;

  bank_decode u_decode (
    .addr(req_addr),
    .hit(dec_hit),
    .bank(dec_bank),
    .offset(dec_offset)
  );

  wire [1:0] req_width;
  wire [`WAIT_BITS-1:0] rd_wait;
  wire [`WAIT_BITS-1:0] wr_wait;

  // each bank has its own width and wait fields
  assign req_width = cfg_width[dec_bank*`WIDTH_FIELD +: `WIDTH_FIELD];
  assign rd_wait = cfg_rd_wait[bank_r*`WAIT_BITS +: `WAIT_BITS];
  assign wr_wait = cfg_wr_wait[bank_r*`WAIT_BITS +: `WAIT_BITS];

  // ==========================================
  // beat geometry for the bank width
  reg [1:0] last_beat;
  reg [4:0] lane_shift;
  reg [31:0] lane_mask;
  reg [23:0] beat_addr;
  reg [31:0] beat_wdata;
  reg [31:0] beat_rdata;

  always @* begin
    case (width_r)
      `WIDTH_8: begin
        last_beat = 2'h3;
        lane_shift = {beat_r, 3'h0};
        lane_mask = 32'h0000_00ff;
        beat_addr = {offset_r[21:0], beat_r};
      end
      `WIDTH_16: begin
        last_beat = 2'h1;
        lane_shift = {beat_r[0], 4'h0};
        lane_mask = 32'h0000_ffff;
        beat_addr = {offset_r[22:0], beat_r[0]};
      end
      default: begin
        last_beat = 2'h0;
        lane_shift = 5'h00;
        lane_mask = 32'hffff_ffff;
        beat_addr = offset_r;
      end
    endcase
    // only the selected lanes carry data
    beat_wdata = (wdata_r >> lane_shift) & lane_mask;
    beat_rdata = rbuf_r | ((data_s2_r & lane_mask) << lane_shift);
  end

  // ==========================================
  // strobe timer
  reg timer_load;
  wire timer_expired;
  wire beat_end;
  wire access_last;

  always @* begin
    timer_load = (state_r == ST_SETUP) && cond_r;
  end

  beat_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(timer_load),
    .load_val(wr_r ? wr_wait : rd_wait),
    .ack_ok(ack_s2_r),
    .expired(timer_expired)
  );

  // strobe spans both synchroniser stages before ack or data is trusted,
  // so a short wait count cannot end a beat on pre-strobe pin values
  assign beat_end = timer_expired && (strobe_age_r == `STROBE_MIN_AGE);

  // last beat of an access: selects drop together with busy_r
  assign access_last = (state_r == ST_END) && (beat_r == last_beat || !cond_r);

  // ==========================================
  // access sequencer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      sel_r <= `SEL_IDLE;
      wr_r <= 1'b0;
      cond_r <= 1'b0;
      bank_r <= 2'h0;
      offset_r <= 24'h00_0000;
      width_r <= `WIDTH_32;
      beat_r <= 2'h0;
      wdata_r <= 32'h0000_0000;
      rbuf_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      addr_err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      addr_o_r <= `ADDR_AFTER_RESET;
      data_o_r <= 32'h0000_0000;
      data_oe_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      strobe_age_r <= 2'h0;
    end else begin
      done_r <= 1'b0;
      addr_err_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          sel_r <= `SEL_IDLE;
          if (req) begin
            if (!dec_hit || !ext_memory_pin_mode_r) begin
              done_r <= 1'b1;
              addr_err_r <= 1'b1;
            end else begin
              busy_r <= 1'b1;
              wr_r <= req_wr;
              cond_r <= req_cond_true;
              bank_r <= dec_bank;
              offset_r <= dec_offset;
              width_r <= req_width;
              wdata_r <= req_wdata;
              beat_r <= 2'h0;
              rbuf_r <= 32'h0000_0000;
              // address and select change together
              sel_r <= ~(4'h1 << dec_bank);
              state_r <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          addr_o_r <= beat_addr;
          strobe_age_r <= 2'h0;
          if (cond_r) begin
            if (wr_r) begin
              wr_n_r <= 1'b0;
              data_o_r <= beat_wdata;
              data_oe_r <= 1'b1;
            end else begin
              rd_n_r <= 1'b0;
            end
            state_r <= ST_STROBE;
          end else begin
            // false condition: select only, no strobe
            state_r <= ST_END;
          end
        end
        ST_STROBE: begin
          // age saturates, the count and ack decide the rest
          if (strobe_age_r != `STROBE_MIN_AGE) begin
            strobe_age_r <= strobe_age_r + 1'b1;
          end
          if (beat_end) begin
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            if (!wr_r) begin
              rbuf_r <= beat_rdata;
            end
            state_r <= ST_END;
          end
        end
        ST_END: begin
          data_oe_r <= 1'b0;
          if (access_last) begin
            // at least five cycles per beat, one beat per word on 32-bit banks
            sel_r <= `SEL_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b1;
            rdata_r <= rbuf_r;
            state_r <= ST_IDLE;
          end else begin
            // next beat: new address and strobe from setup
            beat_r <= beat_r + 1'b1;
            state_r <= ST_SETUP;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // pin drive and multiplexing
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_oe_r <= 1'b0;
      ctl_oe_r <= 1'b0;
      bank_select_n_r <= 2'h3;
      flag_o_r <= 2'h3;
      flag_oe_r <= 2'h0;
      flag_pu_en_r <= 2'h0;
      ext_memory_pin_mode_r <= 1'b1;
    end else begin
      // pulled during reset, driven from the first edge after
      addr_oe_r <= 1'b1;
      ctl_oe_r <= 1'b1;
      // selects follow sel_r a cycle late, in step with the address,
      // but release in the done cycle
      bank_select_n_r <= access_last ? 2'h3 : sel_r[1:0];
      flag_o_r <= access_last ? 2'h3 : sel_r[3:2];
      flag_oe_r <= cfg_flag_sel_mode;
      flag_pu_en_r <= cfg_flag_sel_mode;
      // data pins handed to another function only when idle
      if (state_r == ST_IDLE) begin
        ext_memory_pin_mode_r <= ~cfg_data_alt;
      end
    end
  end

endmodule

// ==== rtl/bank_decode.v ====
// address decode for the four external banks
// assumes a 32-bit word address from the internal request side
`timescale 1ns/1ps
`include "amc_consts.vh"

module bank_decode (
  // request address
  input wire [31:0] addr,
  // decode result
  output reg hit,
  output reg [1:0] bank,
  output wire [23:0] offset
);

  // offset is the raw low address, windows are not packed together
  assign offset = addr[23:0];

  always @* begin
    hit = 1'b0;
    bank = 2'h0;
    if (addr >= `BANK0_START && addr <= `BANK0_END) begin
      hit = 1'b1;
      bank = 2'h0;
    end else if (addr >= `BANK1_START && addr <= `BANK1_START + `BANK_SPAN) begin
      hit = 1'b1;
      bank = 2'h1;
    end else if (addr >= `BANK2_START && addr <= `BANK2_START + `BANK_SPAN) begin
      hit = 1'b1;
      bank = 2'h2;
    end else if (addr >= `BANK3_START && addr <= `BANK3_START + `BANK_SPAN) begin
      hit = 1'b1;
      bank = 2'h3;
    end
  end

endmodule

// ==== rtl/beat_timer.v ====
// strobe wait counter with acknowledge extension
// assumes ack_ok is already synchronised to clk
`timescale 1ns/1ps
`include "amc_consts.vh"

module beat_timer (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control
  input wire load,
  input wire [`WAIT_BITS-1:0] load_val,
  input wire ack_ok,
  // status
  output wire expired
);

  reg [`WAIT_BITS-1:0] cnt_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= {`WAIT_BITS{1'b0}};
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != {`WAIT_BITS{1'b0}}) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // programmed count first, then held while ack is low
  assign expired = (cnt_r == {`WAIT_BITS{1'b0}}) && ack_ok;

endmodule

// ==== tb/mem_ctrl_properties.sv ====
// concurrent checks on the memory controller pins
// assumes one clock domain and bind onto async_mem_ctrl
`timescale 1ns/1ps
module mem_ctrl_properties (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // core side
  input wire req,
  input wire req_cond_true,
  input wire busy_r,
  input wire done_r,
  input wire addr_err_r,
  input wire [1:0] cfg_flag_sel_mode,
  // pins
  input wire [23:0] addr_o_r,
  input wire addr_oe_r,
  input wire data_oe_r,
  input wire ack_i,
  input wire [1:0] bank_select_n_r,
  input wire rd_n_r,
  input wire wr_n_r,
  input wire ctl_oe_r,
  input wire [1:0] flag_oe_r,
  input wire [1:0] flag_o_r,
  input wire [1:0] flag_pu_en_r,
  input wire ext_memory_pin_mode_r
);
  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence no_strobe4;
    (rd_n_r && wr_n_r) [*4];
  endsequence
  sequence refused;
    done_r && addr_err_r;
  endsequence
  idle_quiet_a:
    assert property (!busy_r |-> bank_select_n_r == 2'h3 && rd_n_r && wr_n_r) else $error("pin active while idle");
  read_strobe_a:
    assert property (!rd_n_r |-> busy_r && wr_n_r && !data_oe_r) else $error("bad read strobe");
  write_strobe_a:
    assert property (!wr_n_r |-> busy_r && data_oe_r) else $error("bad write strobe");
  addr_hold_a:
    assert property ((!rd_n_r || !wr_n_r) && $past(!rd_n_r || !wr_n_r) |-> $stable(addr_o_r) && addr_oe_r)
      else $error("address moved in strobe");
  ack_stretch_a:
    assert property (!rd_n_r && !$past(ack_i) && !$past(ack_i, 2) && !$past(ack_i, 3) |=> !rd_n_r)
      else $error("strobe ended while ack low");
  err_done_a:
    assert property (addr_err_r |-> done_r) else $error("error without done");
  accept_a:
    assert property (req && !busy_r && ext_memory_pin_mode_r |=> busy_r or refused) else $error("request lost");
  mode_refuse_a:
    assert property (req && !busy_r && !ext_memory_pin_mode_r |=> refused) else $error("access in other pin mode");
  cond_quiet_a:
    assert property (req && !busy_r && !req_cond_true |=> no_strobe4) else $error("strobe on false condition");
  reset_drive_a:
    assert property ($past(rst_b) |-> addr_oe_r && ctl_oe_r) else $error("pins not driven after reset");
  flag_mode_a:
    assert property ($past(rst_b) |-> flag_oe_r == $past(cfg_flag_sel_mode)) else $error("flag pin mode wrong");
  flag_pullup_a:
    assert property ($past(rst_b) |-> flag_pu_en_r == $past(cfg_flag_sel_mode)) else $error("flag pull-up wrong");
  sel_onehot_a:
    assert property ($countones(~{flag_o_r, bank_select_n_r}) <= 1) else $error("two bank selects active");
  flag_select_a:
    assert property (flag_o_r != 2'h3 |-> busy_r) else $error("flag select active while idle");
endmodule
bind async_mem_ctrl mem_ctrl_properties i_mem_ctrl_properties (.*);

// ==== tb/sram_model.sv ====
// asynchronous memory on the far side of the pins
// assumes word index from low address bits, pull-ups on data and ack
`timescale 1ns/1ps
module sram_model (
  // clock
  input wire clk,
  // pins from controller
  input wire [23:0] addr,
  input wire rd_n,
  input wire wr_n,
  input wire [31:0] wdata,
  input wire wdata_oe,
  // test control
  input wire [3:0] ack_wait,
  // pins to controller
  output wire [31:0] data,
  output wire ack
);
  reg [31:0] mem [0:31];
  reg [3:0] hold_r = 4'h0;
  reg idle_r = 1'b1;
  integer i;
  // ====
  // storage and pins
  initial for (i = 0; i < 32; i = i + 1) mem[i] = {4{3'h0, i[4:0]}};
  assign data = wdata_oe ? wdata : (!rd_n ? mem[addr[4:0]] : 32'hffff_ffff);
  assign ack = hold_r == 4'h0;
  always @(posedge clk) begin
    idle_r <= rd_n & wr_n;
    if (idle_r && !(rd_n & wr_n))
      hold_r <= ack_wait;
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
    if (!wr_n)
      mem[addr[4:0]] <= wdata;
  end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for async_mem_ctrl
// assumes sram_model on the pins and rtl/ on the include path
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg req = 1'b0;
  reg req_wr = 1'b0;
  reg req_cond_true = 1'b1;
  reg [31:0] req_addr = 32'h0;
  reg [31:0] req_wdata = 32'h0;
  reg [1:0] cfg_flag_sel_mode = 2'h3;
  reg cfg_data_alt = 1'b0;
  reg [3:0] ack_wait = 4'h0;
  wire [7:0] cfg_width = 8'he4;
  wire [15:0] cfg_rd_wait = 16'h5432;
  wire [15:0] cfg_wr_wait = 16'h2222;
  wire busy_r, done_r, addr_err_r, addr_oe_r, data_oe_r, ack_i, rd_n_r, wr_n_r, ctl_oe_r, ext_memory_pin_mode_r;
  wire [31:0] rdata_r, data_i, data_o_r;
  wire [23:0] addr_o_r;
  wire [1:0] bank_select_n_r, flag_o_r, flag_oe_r, flag_pu_en_r;
  integer n_errors = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer ticks = 0;
  async_mem_ctrl i_async_mem_ctrl (.*);
  sram_model i_sram_model (.clk(clk), .addr(addr_o_r), .rd_n(rd_n_r), .wr_n(wr_n_r), .wdata(data_o_r),
    .wdata_oe(data_oe_r), .ack_wait(ack_wait), .data(data_i), .ack(ack_i));
  // ====
  // tasks
  initial forever #12.5 clk = ~clk;
  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task do_reset;
    begin
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check({addr_oe_r, ctl_oe_r, data_oe_r, flag_oe_r}, 32'h0);
      check({bank_select_n_r, rd_n_r, wr_n_r, busy_r, ext_memory_pin_mode_r}, 32'h3d);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({addr_oe_r, ctl_oe_r, addr_o_r, flag_oe_r}, {2'h3, 24'h0, cfg_flag_sel_mode});
      $display("test reset done");
    end
  endtask
  task op(input w, input c, input [31:0] a, input [31:0] d, input [31:0] x, input e, input integer n);
    begin
      @(posedge clk);
      req <= 1'b1;
      req_wr <= w;
      req_cond_true <= c;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      #1;
      cyc = 1;
      while (done_r !== 1'b1 && cyc < 100) begin
        @(posedge clk);
        #1;
        cyc = cyc + 1;
      end
      check(done_r, 1'b1);
      check(addr_err_r, e);
      if (n > 0)
        check(cyc, n);
      if (!w && c && !e)
        check(rdata_r, x);
    end
  endtask
  // ====
  // tests
  always @(posedge clk) begin
    ticks = ticks + 1;
    if (ticks == 5000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  initial begin
    do_reset;
    op(0, 1, 32'h0020_0002, 0, 32'h0b0a_0908, 0, 21);
    op(0, 1, 32'h0400_0003, 0, 32'h0707_0606, 0, 13);
    op(0, 1, 32'h0800_0005, 0, 32'h0505_0505, 0, 8);
    op(0, 1, 32'h0cff_fff1, 0, 32'h1111_1111, 0, 9);
    $display("test widths done");
    op(1, 1, 32'h0800_0004, 32'h1234_5678, 0, 0, 6);
    op(0, 1, 32'h0800_0004, 0, 32'h1234_5678, 0, 8);
    op(1, 1, 32'h0020_0003, 32'haabb_ccdd, 0, 0, 21);
    op(0, 1, 32'h0020_0003, 0, 32'haabb_ccdd, 0, 21);
    $display("test writes done");
    op(0, 1, 32'h001f_ffff, 0, 0, 1, 1);
    op(1, 1, 32'h0100_0000, 0, 0, 1, 1);
    op(0, 1, 32'h0d00_0000, 0, 0, 1, 1);
    op(0, 0, 32'h0400_0003, 0, 0, 0, 3);
    $display("test decode done");
    @(posedge clk);
    ack_wait <= 4'h6;
    op(0, 1, 32'h0800_0005, 0, 32'h0505_0505, 0, 0);
    check(cyc > 8, 1);
    @(posedge clk);
    ack_wait <= 4'h0;
    $display("test ack done");
    @(posedge clk);
    cfg_data_alt <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(ext_memory_pin_mode_r, 0);
    op(0, 1, 32'h0800_0005, 0, 0, 1, 1);
    @(posedge clk);
    cfg_data_alt <= 1'b0;
    cfg_flag_sel_mode <= 2'h1;
    $display("test pin mode done");
    do_reset;
    op(0, 1, 32'h0020_0002, 0, 32'h0b0a_0908, 0, 21);
    print_verdict;
  end
endmodule
